//--- rtl/ubc_baud_ctrl.sv
// ubc_baud_ctrl.sv: baud rate generator and receiver/transmitter enable control
// assumes: all inputs synchronous to clk except the serial clock pin, which is synchronised here
`timescale 1ns/1ps
`include "ubc_defines.svh"
module ubc_baud_ctrl
  import ubc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic [1:0]  clock_source_select,
  input  wire logic [15:0] baud_divisor,
  input  wire logic        sync_mode,
  input  wire logic        card_mode,
  input  wire logic        over8,
  input  wire logic        clock_output_enable,
  input  wire logic [10:0] etu_ratio_wdata,
  input  wire logic        etu_ratio_we,
  input  wire logic        sck_in,
  input  wire logic        cmd_strobe,
  input  wire logic        rx_enable_cmd,
  input  wire logic        rx_disable_cmd,
  input  wire logic        rx_reset_cmd,
  input  wire logic        tx_enable_cmd,
  input  wire logic        tx_disable_cmd,
  input  wire logic        tx_reset_cmd,
  input  wire logic        rx_char_busy,
  input  wire logic        tx_shift_busy,
  input  wire logic        tx_holding_full,
  input  wire logic        tx_timeguard_busy,
  output logic             sck_out,
  output logic             sck_oe,
  output logic             sample_tick,
  output logic             bit_tick,
  output logic             rx_enabled,
  output logic             tx_enabled,
  output logic             rx_soft_rst,
  output logic             tx_soft_rst,
  output logic [10:0]      etu_ratio_field,
  output logic             baud_active
);

  ////////////////////////////////////////////////////////////////////////////
  // pin clock crossing and edge detect

  logic       sck_s1_r;
  logic       sck_s2_r;
  logic       sck_s3_r;
  logic       sck_rise;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
    end
    else if (ce)
    begin
      sck_s1_r <= sck_in;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
    end
  end

  // only the second and third stages are looked at
  assign sck_rise = sck_s2_r && !sck_s3_r;

  ////////////////////////////////////////////////////////////////////////////
  // source selection

  logic [3:0] pre_cnt_r;
  logic       pre_tick;
  logic       src_tick;
  ubc_mode_e  mode;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pre_cnt_r <= 4'h0;
    else if (ce)
      pre_cnt_r <= pre_tick ? 4'h0 : pre_cnt_r + 4'h1;
  end

  assign pre_tick = pre_cnt_r == (`UBC_PRESCALE - 4'h1);

  // the unused select code 2 is treated as the master clock
  always_comb
  begin
    case (clock_source_select)
      `UBC_SEL_MCK_DIV: src_tick = pre_tick;
      `UBC_SEL_EXT:     src_tick = sck_rise;
      default:          src_tick = 1'b1;
    endcase
  end

  always_comb
  begin
    if (card_mode)
      mode = UBC_MODE_CARD;
    else if (sync_mode)
      mode = UBC_MODE_SYNC;
    else
      mode = UBC_MODE_ASYNC;
  end

  ////////////////////////////////////////////////////////////////////////////
  // divisor stage

  logic        div_tick;
  logic        div_half;
  logic        div_clr;
  logic        ext_direct;

  assign ext_direct = mode == UBC_MODE_SYNC && clock_source_select == `UBC_SEL_EXT;
  assign div_clr    = rx_soft_rst && tx_soft_rst;

  ubc_tick_div #(
    .W        (`UBC_DIV_W)
  ) u_cd_div (
    .clk      (clk),
    .resetn   (resetn),
    .ce       (ce),
    .clr      (div_clr),
    .tick_in  (src_tick),
    .divisor  (baud_divisor),
    .tick_out (div_tick),
    .half_hi  (div_half)
  );

  // divisor one degenerates to the source tick itself; the mux bypasses the divisor only for the external clock in sync mode
  logic base_tick;
  assign base_tick = ext_direct ? src_tick : div_tick;

  ////////////////////////////////////////////////////////////////////////////
  // oversampling and card dividers

  logic [4:0]  over_div;
  logic        over_tick;
  logic        etu_tick;
  logic [15:0] over_div_w;
  logic [15:0] etu_div_w;

  assign over_div   = over8 ? `UBC_OVER8_DIV : `UBC_OVER16_DIV;
  assign over_div_w = {11'h000, over_div};
  assign etu_div_w  = {5'h00, etu_ratio_field};

  ubc_tick_div #(
    .W        (`UBC_DIV_W)
  ) u_over_div (
    .clk      (clk),
    .resetn   (resetn),
    .ce       (ce),
    .clr      (rx_soft_rst),
    .tick_in  (base_tick && mode == UBC_MODE_ASYNC),
    .divisor  (over_div_w),
    .tick_out (over_tick),
    .half_hi  ()
  );

  ubc_tick_div #(
    .W        (`UBC_DIV_W)
  ) u_etu_div (
    .clk      (clk),
    .resetn   (resetn),
    .ce       (ce),
    .clr      (rx_soft_rst && tx_soft_rst),
    .tick_in  (base_tick && mode == UBC_MODE_CARD),
    .divisor  (etu_div_w),
    .tick_out (etu_tick),
    .half_hi  ()
  );

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      etu_ratio_field <= `UBC_ETU_RESET;
    else if (ce && etu_ratio_we)
      etu_ratio_field <= etu_ratio_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock outputs

  logic bit_nxt;
  logic sample_nxt;

  always_comb
  begin
    case (mode)
      UBC_MODE_ASYNC:
      begin
        sample_nxt = base_tick;
        bit_nxt    = over_tick;
      end
      UBC_MODE_SYNC:
      begin
        sample_nxt = base_tick;
        bit_nxt    = base_tick;
      end
      UBC_MODE_CARD:
      begin
        sample_nxt = base_tick;
        bit_nxt    = etu_tick;
      end
      default:
      begin
        sample_nxt = 1'b0;
        bit_nxt    = 1'b0;
      end
    endcase
  end

  // pin waveform: high in the first half of each divisor period
  logic sck_nxt;
  logic drive_nxt;
  logic mck_src;

  // select code 2 acts as the master clock here as well
  assign mck_src   = clock_source_select != `UBC_SEL_MCK_DIV && clock_source_select != `UBC_SEL_EXT;
  assign drive_nxt = ((mode == UBC_MODE_SYNC && !ext_direct) || mode == UBC_MODE_CARD)
                     && clock_output_enable;

  always_comb
  begin
    if (baud_divisor == 16'h0000)
      sck_nxt = 1'b0;
    else if (baud_divisor == 16'h0001 && mck_src)
      sck_nxt = sck_out;
    else if (baud_divisor == 16'h0001 && clock_source_select == `UBC_SEL_MCK_DIV)
      sck_nxt = pre_cnt_r < (`UBC_PRESCALE >> 1);
    else if (baud_divisor == 16'h0001)
      sck_nxt = sck_s2_r;
    else if (mck_src)
      sck_nxt = div_half;
    else
      sck_nxt = div_half;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sample_tick <= 1'b0;
      bit_tick    <= 1'b0;
      baud_active <= 1'b0;
    end
    else if (ce)
    begin
      sample_tick <= sample_nxt;
      bit_tick    <= bit_nxt;
      baud_active <= ext_direct || baud_divisor != 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sck_out <= 1'b0;
      sck_oe  <= 1'b0;
    end
    else if (ce)
    begin
      // a divisor of one with the master clock toggles every cycle: half the rate, even duty
      sck_out <= (baud_divisor == 16'h0001 && mck_src) ? !sck_out : sck_nxt;
      sck_oe  <= drive_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver and transmitter enable control

  logic rx_en_w;
  logic tx_en_w;
  logic rx_rst_w;
  logic tx_rst_w;
  logic tx_busy;

  assign tx_busy = tx_shift_busy || tx_holding_full || tx_timeguard_busy;

  ubc_dir_ctrl u_rx_ctrl (
    .clk      (clk),
    .resetn   (resetn),
    .ce       (ce),
    .en_cmd   (cmd_strobe && rx_enable_cmd),
    .dis_cmd  (cmd_strobe && rx_disable_cmd),
    .rst_cmd  (cmd_strobe && rx_reset_cmd),
    .busy     (rx_char_busy),
    .enabled  (rx_en_w),
    .soft_rst (rx_rst_w)
  );

  ubc_dir_ctrl u_tx_ctrl (
    .clk      (clk),
    .resetn   (resetn),
    .ce       (ce),
    .en_cmd   (cmd_strobe && tx_enable_cmd),
    .dis_cmd  (cmd_strobe && tx_disable_cmd),
    .rst_cmd  (cmd_strobe && tx_reset_cmd),
    .busy     (tx_busy),
    .enabled  (tx_en_w),
    .soft_rst (tx_rst_w)
  );

  // separate instances keep the two directions independent
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_enabled  <= 1'b0;
      tx_enabled  <= 1'b0;
      rx_soft_rst <= 1'b0;
      tx_soft_rst <= 1'b0;
    end
    else if (ce)
    begin
      rx_enabled  <= rx_en_w && !(cmd_strobe && rx_reset_cmd);
      tx_enabled  <= tx_en_w && !(cmd_strobe && tx_reset_cmd);
      rx_soft_rst <= rx_rst_w;
      tx_soft_rst <= tx_rst_w;
    end
  end

endmodule : ubc_baud_ctrl

//--- rtl/ubc_defines.svh
// ubc_defines.svh: widths, reset values, select codes and timing counts for the baud and enable block
// assumes: included by bare name from the package and from ubc_baud_ctrl
`ifndef UBC_DEFINES_SVH
`define UBC_DEFINES_SVH

`define UBC_DIV_W          16
`define UBC_ETU_W          11
`define UBC_ETU_RESET      11'h174
`define UBC_PRESCALE       4'h8
`define UBC_SEL_MCK        2'h0
`define UBC_SEL_MCK_DIV    2'h1
`define UBC_SEL_EXT        2'h3
`define UBC_OVER8_DIV      5'h08
`define UBC_OVER16_DIV     5'h10

`endif

//--- rtl/ubc_dir_ctrl.sv
// ubc_dir_ctrl.sv: enable state of one direction (receive or transmit)
// assumes: command strobes are one-cycle pulses; busy is driven by the datapath
`timescale 1ns/1ps
module ubc_dir_ctrl
  import ubc_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic ce,
  input  wire logic en_cmd,
  input  wire logic dis_cmd,
  input  wire logic rst_cmd,
  input  wire logic busy,
  output logic      enabled,
  output logic      soft_rst
);
  ubc_dir_e st_r;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st_r <= UBC_DIR_OFF;
    else if (ce)
    begin
      if (rst_cmd)
        st_r <= UBC_DIR_OFF;
      else if (dis_cmd)
        // a direction that is already off has nothing to drain
        st_r <= (busy && st_r != UBC_DIR_OFF) ? UBC_DIR_DRAIN : UBC_DIR_OFF;
      else if (en_cmd)
        st_r <= UBC_DIR_ON;
      else
      begin
        case (st_r)
          UBC_DIR_DRAIN: if (!busy) st_r <= UBC_DIR_OFF;
          default:       st_r <= st_r;
        endcase
      end
    end
  end

  assign enabled  = st_r != UBC_DIR_OFF;
  assign soft_rst = ce && rst_cmd;
endmodule : ubc_dir_ctrl

//--- rtl/ubc_pkg.sv
// ubc_pkg.sv: types shared by the baud and enable control block
// assumes: ubc_defines.svh is on the include path
package ubc_pkg;
  `include "ubc_defines.svh"

  typedef enum logic [1:0] {UBC_MODE_ASYNC, UBC_MODE_SYNC, UBC_MODE_CARD} ubc_mode_e;
  typedef enum logic [1:0] {UBC_DIR_OFF, UBC_DIR_ON, UBC_DIR_DRAIN} ubc_dir_e;
endpackage : ubc_pkg

//--- rtl/ubc_tick_div.sv
// ubc_tick_div.sv: divides a stream of one-cycle ticks by a programmable count
// assumes: ticks are single-cycle pulses on clk; a divisor of zero stops the output
`timescale 1ns/1ps
module ubc_tick_div
  import ubc_pkg::*;
#(
  parameter int W = 16
)
(
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic         clr,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] divisor,
  output logic              tick_out,
  output logic              half_hi
);
  logic [W-1:0] cnt_r;

  // count down from divisor-1; half_hi marks the first half of the period
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cnt_r <= '0;
    else if (ce)
    begin
      if (clr || divisor == '0)
        cnt_r <= '0;
      else if (tick_in)
      begin
        if (cnt_r == '0)
          cnt_r <= divisor - W'(1);
        else
          cnt_r <= cnt_r - W'(1);
      end
    end
  end

  assign tick_out = ce && !clr && tick_in && divisor != '0 && cnt_r == '0;
  assign half_hi  = cnt_r >= (divisor >> 1);
endmodule : ubc_tick_div

//--- test/testbench.sv
// testbench.sv: self-checking bench for the baud and enable block
// assumes: ubc_pin_src plays the external clock on the pin
`timescale 1ns/1ps
module testbench
  import ubc_pkg::*;
;
  logic        clk = 0, resetn = 0, ce = 1, sck_in, pin_run = 0;
  logic [1:0]  clock_source_select = 0;
  logic [15:0] baud_divisor = 1;
  logic        sync_mode = 0, card_mode = 0, over8 = 0, clock_output_enable = 0;
  logic [10:0] etu_ratio_wdata = 0, etu_ratio_field;
  logic        etu_ratio_we = 0, cmd_strobe = 0, rx_m = 0, tx_m = 0, p;
  logic        rx_enable_cmd = 0, rx_disable_cmd = 0, rx_reset_cmd = 0;
  logic        tx_enable_cmd = 0, tx_disable_cmd = 0, tx_reset_cmd = 0;
  logic        rx_char_busy = 0, tx_shift_busy = 0, tx_holding_full = 0, tx_timeguard_busy = 0;
  logic        sck_out, sck_oe, sample_tick, bit_tick, rx_enabled, tx_enabled;
  logic        rx_soft_rst, tx_soft_rst, baud_active;
  logic [5:0]  b;
  logic [1:0]  rst_seen;
  logic [5:0]  fixed [4] = '{6'h20, 6'h04, 6'h36, 6'h24};
  int          err_total = 0, checked = 0, cyc = 0, n, s, d, md, r;
  ubc_baud_ctrl ubc_baud_ctrl_inst (.*);
  ubc_pin_src ubc_pin_src_inst (.run(pin_run), .sck(sck_in));
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_total++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s got %0h want %0h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic cmd(input logic [5:0] c);
    @(posedge clk);
    #1 cmd_strobe = 1;
    {rx_enable_cmd, rx_disable_cmd, rx_reset_cmd, tx_enable_cmd, tx_disable_cmd, tx_reset_cmd} = c;
    @(posedge clk);
    #1 cmd_strobe = 0;
    rst_seen = {rx_soft_rst, tx_soft_rst};
    repeat (2) @(posedge clk);
    #1;
  endtask : cmd
  task automatic gap(input logic bt, output int k);
    k = 0;
    while ((bt ? bit_tick : sample_tick) !== 1'b1 && k < 9000)
    begin
      @(posedge clk);
      #1 k++;
    end
    k = 0;
    do
    begin
      @(posedge clk);
      #1 k++;
    end while ((bt ? bit_tick : sample_tick) !== 1'b1 && k < 9000);
  endtask : gap
  task automatic drain(input logic rst);
    cmd(6'h24);
    rx_char_busy = 1;
    {tx_shift_busy, tx_holding_full, tx_timeguard_busy} = 3'b001 << $urandom_range(2);
    cmd(rst ? 6'h09 : 6'h12);
    repeat (4) @(posedge clk);
    #1 check({rx_enabled, tx_enabled}, {2{!rst}}, "drain hold");
    {rx_char_busy, tx_shift_busy, tx_holding_full, tx_timeguard_busy} = 4'h0;
    repeat (3) @(posedge clk);
    #1 check({rx_enabled, tx_enabled}, 2'b00, "drain end");
  endtask : drain
  // next enable state: reset and disable both beat enable when idle
  function automatic logic nxt(input logic m, input logic [2:0] c);
    return (c[0] || c[1]) ? 1'b0 : (c[2] ? 1'b1 : m);
  endfunction : nxt
  // ratio software loads: division factor over adjust factor, rounded to nearest
  function automatic int etu_ratio(input logic [3:0] fc, input logic [3:0] dc);
    int f;
    int a;
    case (fc)
      4'h2:    f = 558;
      4'h3:    f = 744;
      4'h4:    f = 1116;
      4'h5:    f = 1488;
      4'h6:    f = 1860;
      4'h9:    f = 512;
      4'hA:    f = 768;
      4'hB:    f = 1024;
      4'hC:    f = 1536;
      4'hD:    f = 2048;
      default: f = 372;
    endcase
    case (dc)
      4'h0:    a = 1;
      4'h8:    a = 12;
      4'h9:    a = 20;
      default: a = 1 << (dc - 4'h1);
    endcase
    return (f + a / 2) / a;
  endfunction : etu_ratio
  function automatic int exp_gap(input int sl, input int dv, input logic bt, input int mo);
    int src = (sl == 1) ? 8 : ((sl == 3) ? 6 : 1);
    if (!bt)
      return (mo == 1 && sl == 3) ? src : src * dv;
    if (mo == 1)
      return (sl == 3) ? 6 : src * dv;
    return src * dv * ((mo == 2) ? r : (over8 ? 8 : 16));
  endfunction : exp_gap
  ////////////////////////////////////////////////////////////
  initial
  begin
    n = $urandom(97237);
    repeat (6) @(posedge clk);
    #1 resetn = 1;
    check({rx_enabled, tx_enabled}, 2'b00, "enables after reset");
    check(etu_ratio_field, 11'h174, "ratio reset");
    r = etu_ratio(4'($urandom_range(2)), 4'($urandom_range(6, 5)));
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      #1 etu_ratio_wdata = i ? r[10:0] : 11'h7FF;
      etu_ratio_we = 1;
      @(posedge clk);
      #1 etu_ratio_we = 0;
      check(etu_ratio_field, etu_ratio_wdata, "ratio write");
    end
    for (int i = 0; i < 20; i++)
    begin
      b = (i < 4) ? fixed[i] : 6'($urandom);
      cmd(b);
      rx_m = nxt(rx_m, b[5:3]);
      tx_m = nxt(tx_m, b[2:0]);
      check({rx_enabled, tx_enabled}, {rx_m, tx_m}, "enable state");
      check(rst_seen, {b[3], b[0]}, "soft reset");
    end
    drain(0);
    drain(1);
    for (int i = 0; i < 10; i++)
    begin
      s = (i == 1) ? 3 : ((i == 2) ? 1 : ((i == 0) ? 0 : $urandom_range(3)));
      d = (i == 0) ? 1 : $urandom_range(4, 1);
      md = (i < 3) ? i : $urandom_range(2);
      clock_source_select = s[1:0];
      baud_divisor = d[15:0];
      sync_mode = (md == 1);
      card_mode = (md == 2);
      over8 = 1'($urandom);
      pin_run = (s == 3);
      cmd(6'h09);
      gap(0, n);
      gap(0, n);
      check(n[15:0], exp_gap(s, d, 0, md), "sample gap");
      gap(1, n);
      gap(1, n);
      check(n[15:0], exp_gap(s, d, 1, md), "bit gap");
    end
    pin_run = 0;
    clock_source_select = 0;
    baud_divisor = 0;
    n = 0;
    repeat (100)
    begin
      @(posedge clk);
      #1 if (sample_tick !== 1'b0 || bit_tick !== 1'b0) n++;
    end
    check(n[15:0], 0, "zero divisor");
    check(baud_active, 0, "baud idle");
    {sync_mode, card_mode, clock_output_enable} = 3'b101;
    for (int i = 1; i < 5; i += 3)
    begin
      baud_divisor = i[15:0];
      cmd(6'h09);
      n = 0;
      repeat (8)
      begin
        @(posedge clk);
        #1 if (sck_out === 1'b1) n++;
      end
      check(n[15:0], 4, "pin duty");
      check(sck_oe, 1, "pin drive");
      check(baud_active, 1, "baud running");
    end
    // with clock enable low the pin waveform must hold still
    ce = 0;
    p = sck_out;
    repeat (6) @(posedge clk);
    #1 check(sck_out, p, "frozen pin");
    ce = 1;
    clock_output_enable = 0;
    repeat (3) @(posedge clk);
    #1 check(sck_oe, 0, "pin released");
    finish_test();
  end
endmodule : testbench

//--- test/ubc_baud_ctrl_chk.sv
// ubc_baud_ctrl_chk.sv: port assertions for the baud and enable block
// assumes: bound into ubc_baud_ctrl; ce low freezes the block, so checks pause
`timescale 1ns/1ps
module ubc_chk
  import ubc_pkg::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        ce,
  input wire logic [1:0]  clock_source_select,
  input wire logic [15:0] baud_divisor,
  input wire logic        sync_mode,
  input wire logic        card_mode,
  input wire logic        clock_output_enable,
  input wire logic [10:0] etu_ratio_wdata,
  input wire logic        etu_ratio_we,
  input wire logic        cmd_strobe,
  input wire logic        rx_enable_cmd,
  input wire logic        rx_disable_cmd,
  input wire logic        rx_reset_cmd,
  input wire logic        tx_enable_cmd,
  input wire logic        tx_disable_cmd,
  input wire logic        tx_reset_cmd,
  input wire logic        rx_char_busy,
  input wire logic        sck_oe,
  input wire logic        sample_tick,
  input wire logic        bit_tick,
  input wire logic        rx_enabled,
  input wire logic        tx_enabled,
  input wire logic        rx_soft_rst,
  input wire logic        tx_soft_rst,
  input wire logic [10:0] etu_ratio_field
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn || !ce);
  wire rx_go = cmd_strobe && rx_enable_cmd && !rx_disable_cmd && !rx_reset_cmd;
  wire tx_go = cmd_strobe && tx_enable_cmd && !tx_disable_cmd && !tx_reset_cmd;
  ////////////////////////////////////////////////////////////
  chk_ratio_reset: assert property ($rose(resetn) |-> etu_ratio_field == 11'h174)
    else $error("ratio field wrong after reset");
  chk_ratio_load: assert property (etu_ratio_we |=> etu_ratio_field == $past(etu_ratio_wdata))
    else $error("ratio write lost");
  chk_rx_enable: assert property (rx_go |-> ##2 rx_enabled)
    else $error("receiver not enabled");
  chk_tx_enable: assert property (tx_go |-> ##2 tx_enabled)
    else $error("transmitter not enabled");
  chk_rx_reset: assert property (cmd_strobe && rx_reset_cmd |=> rx_soft_rst && !rx_enabled)
    else $error("receiver reset missing");
  chk_disable_wins: assert property (cmd_strobe && rx_enable_cmd && rx_disable_cmd
    && !rx_enabled && !$past(cmd_strobe) |=> !rx_enabled [*2])
    else $error("enable beat disable");
  chk_rx_drain: assert property (rx_enabled && rx_char_busy && cmd_strobe && rx_disable_cmd
    && !rx_reset_cmd && !$past(cmd_strobe) |=> rx_enabled [*2])
    else $error("receiver stopped mid character");
  chk_zero_stop: assert property ((baud_divisor == 16'h0000 && clock_source_select != 2'h3) [*4]
    |-> !sample_tick && !bit_tick)
    else $error("tick with zero divisor");
  chk_mck_pass: assert property ((baud_divisor == 16'h0001 && !clock_source_select[0]) [*5]
    |-> sample_tick || $past(rx_soft_rst && tx_soft_rst))
    else $error("bypass not every cycle");
  chk_oe_gate: assert property ((!clock_output_enable || !(sync_mode || card_mode)) [*2]
    |-> !sck_oe)
    else $error("pin driven without enable");
  cover property (rx_enabled && tx_enabled);
  cover property (bit_tick && card_mode);
  cover property (rx_soft_rst && rx_char_busy);
endmodule : ubc_chk
bind ubc_baud_ctrl ubc_chk ubc_chk_inst (.*);

//--- test/ubc_pin_src.sv
// ubc_pin_src.sv: external clock source driving the serial clock pin
// assumes: run is set by the bench; the line rests low while stopped
`timescale 1ns/1ps
module ubc_pin_src
  import ubc_pkg::*;
#(
  parameter realtime HALF = 12.0
)
(
  input  wire logic run,
  output logic      sck
);
  initial sck = 1'b0;
  // offset keeps pin edges away from the system clock edges
  always
  begin
    wait (run);
    #1.3 sck = 1'b1;
    #HALF sck = 1'b0;
    #(HALF - 1.3);
  end
endmodule : ubc_pin_src
